// [verilog/adcrw_pkg.sv]
package adcrw_pkg;
	// register indices of the converter's space; index n sits at byte address 4n
	localparam logic [7:0] ADCRW_OFS_DEBUG = 8'h0C;
	localparam logic [7:0] ADCRW_OFS_STAGING = 8'h0D;
	localparam logic [7:0] ADCRW_OFS_RESULT = 8'h10;
	localparam logic [7:0] ADCRW_OFS_WIN_LOW = 8'h12;
	localparam logic [7:0] ADCRW_OFS_WIN_HIGH = 8'h14;
	localparam logic [7:0] ADCRW_OFS_DUTY = 8'h16;
	localparam logic [7:0] ADCRW_OFS_MODE = 8'h04;
	localparam logic [7:0] ADCRW_OFS_FLAGS = 8'h0B;
	localparam logic [7:0] ADCRW_OFS_ACCUM = 8'h18;

	localparam logic [7:0] ADCRW_RST_DUTY = 8'h01;
	localparam logic [7:0] ADCRW_RST_ZERO = 8'h00;
	localparam logic [15:0] ADCRW_RST_WORD = 16'h0000;

	localparam logic [9:0] ADCRW_CODE_MAX = 10'h3FF;
	localparam logic [9:0] ADCRW_CODE_MIN = 10'h000;
	localparam logic [15:0] ADCRW_ACC_CEIL = 16'hFFC0;
	localparam logic [6:0] ADCRW_ACC_MAX_SAMPLES = 7'h40;

	localparam int ADCRW_DUTY_PERIOD = 4;
	localparam logic [1:0] ADCRW_DUTY_QUARTER = 2'h1;
	localparam logic [1:0] ADCRW_DUTY_HALF = 2'h2;

	typedef enum logic [2:0] {
		ADCRW_WIN_NONE = 3'h0,
		ADCRW_WIN_BELOW = 3'h1,
		ADCRW_WIN_ABOVE = 3'h2,
		ADCRW_WIN_INSIDE = 3'h3,
		ADCRW_WIN_OUTSIDE = 3'h4
	} adcrw_win_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} adcrw_apb_req_t;

	typedef struct packed {
		logic valid;
		logic over_ref;
		logic below_gnd;
		logic [9:0] code;
	} adcrw_sample_t;
endpackage : adcrw_pkg

// [verilog/adcrw_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module adcrw_regs
	import adcrw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic cpu_halted_in,
	input wire logic start_event_in,
	input wire adcrw_sample_t sample_in,
	input wire logic [6:0] accum_count_in,
	output logic start_out,
	output logic adc_clk_out,
	output logic result_available_flag_out,
	output logic window_match_flag_out
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	adcrw_apb_req_t req;
	logic acc_wr;
	logic acc_rd;
	logic mapped;
	logic [7:0] idx;

	// one register per aligned word; a misaligned address selects no register
	function automatic logic [7:0] word_index(input logic [7:0] a);
		if (a[1:0] == 2'h0) begin
			word_index = {2'h0, a[7:2]};
		end else begin
			word_index = 8'hFF;
		end
	endfunction : word_index

	assign idx = word_index(paddr_in);
	assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in, paddr: paddr_in, pwdata: pwdata_in};
	assign acc_wr = req.psel & req.penable & req.pwrite;
	assign acc_rd = req.psel & req.penable & ~req.pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		hit = (a[7:1] == base[7:1]);
	endfunction : hit

	function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] stg,
			input logic [7:0] wd);
		// low byte parks in staging, high write commits both halves at once
		if (hi) begin
			put_byte = {wd, stg};
		end else begin
			put_byte = old;
		end
	endfunction : put_byte

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic run_while_halted_q, run_while_halted_d;
	logic [7:0] staging_q, staging_d;
	logic [15:0] result_q, result_d;
	logic [15:0] win_low_q, win_low_d;
	logic [15:0] win_high_q, win_high_d;
	logic clock_duty_select_q, clock_duty_select_d;
	logic [2:0] mode_q, mode_d;
	logic ready_q, ready_d;
	logic match_q, match_d;
	logic [15:0] accum_q, accum_d;
	logic [6:0] count_q, count_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic start_q, start_d;
	logic [1:0] phase_q, phase_d;
	logic adc_clk_q, adc_clk_d;

	logic halted;
	logic [9:0] code;
	logic [15:0] total;
	logic match;
	logic [6:0] target;

	// ----------------------------------------------------------------
	// sample path and window compare
	// ----------------------------------------------------------------
	assign halted = cpu_halted_in & ~run_while_halted_q;
	// saturate out-of-range inputs before they reach the accumulator
	always_comb begin
		if (sample_in.over_ref) begin
			code = ADCRW_CODE_MAX;
		end else if (sample_in.below_gnd) begin
			code = ADCRW_CODE_MIN;
		end else begin
			code = sample_in.code;
		end
	end
	assign total = accum_q + {6'h00, code};
	// a count of zero or beyond the limit falls back to single conversions
	assign target = (accum_count_in == 7'h00 || accum_count_in > ADCRW_ACC_MAX_SAMPLES) ? 7'h01
		: accum_count_in;

	always_comb begin
		case (adcrw_win_t'(mode_q))
			ADCRW_WIN_NONE: match = 1'b0;
			ADCRW_WIN_BELOW: match = total < win_low_q;
			ADCRW_WIN_ABOVE: match = total > win_high_q;
			ADCRW_WIN_INSIDE: match = (total > win_low_q) && (total < win_high_q);
			ADCRW_WIN_OUTSIDE: match = (total < win_low_q) || (total > win_high_q);
			default: match = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic last;
		last = 1'b0;
		run_while_halted_d = run_while_halted_q;
		staging_d = staging_q;
		result_d = result_q;
		win_low_d = win_low_q;
		win_high_d = win_high_q;
		clock_duty_select_d = clock_duty_select_q;
		mode_d = mode_q;
		ready_d = ready_q;
		match_d = match_q;
		accum_d = accum_q;
		count_d = count_q;
		prdata_d = 32'h0000_0000;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		start_d = start_event_in & ~halted;
		mapped = 1'b1;

		// accesses complete in the second cycle after setup, with one wait state; pready is a one-cycle pulse
		if (acc_wr & ~pready_q) begin
			pready_d = 1'b1;
			if (idx == ADCRW_OFS_DEBUG) begin
				run_while_halted_d = pwdata_in[0];
			end else if (idx == ADCRW_OFS_STAGING) begin
				staging_d = pwdata_in[7:0];
			end else if (hit(idx, ADCRW_OFS_WIN_LOW)) begin
				if (!idx[0]) staging_d = pwdata_in[7:0];
				win_low_d = put_byte(win_low_q, idx[0], staging_q, pwdata_in[7:0]);
			end else if (hit(idx, ADCRW_OFS_WIN_HIGH)) begin
				if (!idx[0]) staging_d = pwdata_in[7:0];
				win_high_d = put_byte(win_high_q, idx[0], staging_q, pwdata_in[7:0]);
			end else if (idx == ADCRW_OFS_DUTY) begin
				clock_duty_select_d = pwdata_in[0];
			end else if (idx == ADCRW_OFS_MODE) begin
				mode_d = pwdata_in[2:0];
			end else if (idx == ADCRW_OFS_FLAGS) begin
				if (pwdata_in[0]) ready_d = 1'b0;
				if (pwdata_in[1]) match_d = 1'b0;
			end else if (hit(idx, ADCRW_OFS_RESULT)) begin
				pslverr_d = 1'b1; // read-only
			end else begin
				mapped = 1'b0;
			end
		end else if (acc_rd & ~pready_q) begin
			pready_d = 1'b1;
			if (idx == ADCRW_OFS_DEBUG) begin
				prdata_d = {31'h0, run_while_halted_q};
			end else if (idx == ADCRW_OFS_STAGING) begin
				prdata_d = {24'h0, staging_q};
			end else if (hit(idx, ADCRW_OFS_RESULT)) begin
				if (!idx[0]) begin
					prdata_d = {24'h0, result_q[7:0]};
					staging_d = result_q[15:8];
					ready_d = 1'b0;
					match_d = 1'b0;
				end else begin
					prdata_d = {24'h0, staging_q};
				end
			end else if (hit(idx, ADCRW_OFS_WIN_LOW)) begin
				prdata_d = {24'h0, idx[0] ? staging_q : win_low_q[7:0]};
				if (!idx[0]) staging_d = win_low_q[15:8];
			end else if (hit(idx, ADCRW_OFS_WIN_HIGH)) begin
				prdata_d = {24'h0, idx[0] ? staging_q : win_high_q[7:0]};
				if (!idx[0]) staging_d = win_high_q[15:8];
			end else if (idx == ADCRW_OFS_DUTY) begin
				prdata_d = {31'h0, clock_duty_select_q};
			end else if (idx == ADCRW_OFS_MODE) begin
				prdata_d = {29'h0, mode_q};
			end else if (idx == ADCRW_OFS_FLAGS) begin
				prdata_d = {30'h0, match_q, ready_q};
			end else if (idx == ADCRW_OFS_ACCUM) begin
				prdata_d = {25'h0, count_q};
			end else begin
				mapped = 1'b0;
			end
		end
		// refused addresses answer with an error and touch no state
		if (!mapped) begin
			pslverr_d = 1'b1;
		end

		// sample path: frozen while halted, hardware set wins over any clear above
		if (sample_in.valid & ~halted) begin
			last = (count_q + 7'h01) >= target;
			if (last) begin
				result_d = (total > ADCRW_ACC_CEIL) ? ADCRW_ACC_CEIL : total;
				ready_d = 1'b1;
				if (match) match_d = 1'b1;
				accum_d = ADCRW_RST_WORD;
				count_d = 7'h00;
			end else begin
				accum_d = total;
				count_d = count_q + 7'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// converter clock: quarter or half high over a four-cycle period
	// ----------------------------------------------------------------
	always_comb begin
		phase_d = phase_q + 2'h1;
		if (halted) begin
			phase_d = phase_q;
		end
		adc_clk_d = clock_duty_select_q ? (phase_d < ADCRW_DUTY_QUARTER)
			: (phase_d < ADCRW_DUTY_HALF);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_while_halted_q <= 1'b0;
			staging_q <= ADCRW_RST_ZERO;
			result_q <= ADCRW_RST_WORD;
			win_low_q <= ADCRW_RST_WORD;
			win_high_q <= ADCRW_RST_WORD;
			clock_duty_select_q <= ADCRW_RST_DUTY[0];
			mode_q <= 3'h0;
			ready_q <= 1'b0;
			match_q <= 1'b0;
			accum_q <= ADCRW_RST_WORD;
			count_q <= 7'h00;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			start_q <= 1'b0;
			phase_q <= 2'h0;
			adc_clk_q <= 1'b0;
		end else begin
			run_while_halted_q <= run_while_halted_d;
			staging_q <= staging_d;
			result_q <= result_d;
			win_low_q <= win_low_d;
			win_high_q <= win_high_d;
			clock_duty_select_q <= clock_duty_select_d;
			mode_q <= mode_d;
			ready_q <= ready_d;
			match_q <= match_d;
			accum_q <= accum_d;
			count_q <= count_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			start_q <= start_d;
			phase_q <= phase_d;
			adc_clk_q <= adc_clk_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign start_out = start_q;
	assign adc_clk_out = adc_clk_q;
	assign result_available_flag_out = ready_q;
	assign window_match_flag_out = match_q;
endmodule : adcrw_regs
`default_nettype wire

// [tb/adcrw_regs_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module adcrw_regs_sva
	import adcrw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic cpu_halted_in,
	input wire logic start_event_in,
	input wire adcrw_sample_t sample_in,
	input wire logic [6:0] accum_count_in,
	input wire logic start_out,
	input wire logic adc_clk_out,
	input wire logic result_available_flag_out,
	input wire logic window_match_flag_out
);
	// ----------------------------------------
	// protocol and flag checks
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_READY_ONE: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
	AST_READY_ANSWER: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("no ready");
	AST_READY_IDLE: assert property (!psel_in |=> !pready_out) else $error("ready without select");
	AST_RESULT_RO: assert property (psel_in && penable_in && !pready_out && pwrite_in
		&& paddr_in == {ADCRW_OFS_RESULT[5:0], 2'h0} |=> pslverr_out) else $error("result write accepted");
	AST_START_RUN: assert property (start_event_in && !cpu_halted_in |=> start_out) else $error("event lost");
	AST_START_CAUSE: assert property (start_out |-> $past(start_event_in)) else $error("start without event");
	AST_READ_CLEARS: assert property (psel_in && penable_in && !pready_out && !pwrite_in
		&& paddr_in == {ADCRW_OFS_RESULT[5:0], 2'h0}
		&& !sample_in.valid |=> ##[0:1] !result_available_flag_out && !window_match_flag_out)
		else $error("flags kept after result read");
	AST_READY_CAUSE: assert property ($rose(result_available_flag_out) |-> $past(sample_in.valid))
		else $error("ready flag without sample");
	AST_MATCH_CAUSE: assert property ($rose(window_match_flag_out) |-> $past(sample_in.valid))
		else $error("match flag without sample");
	AST_DUTY_MAXHIGH: assert property (adc_clk_out [*3] |-> $past(cpu_halted_in) || $past(cpu_halted_in, 2))
		else $error("converter clock high too long");
	cover property (pslverr_out);
	cover property ($rose(window_match_flag_out));
	cover property (start_out);
endmodule : adcrw_regs_sva
bind adcrw_regs adcrw_regs_sva u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .cpu_halted_in(cpu_halted_in),
	.start_event_in(start_event_in), .sample_in(sample_in), .accum_count_in(accum_count_in), .start_out(start_out),
	.adc_clk_out(adc_clk_out), .result_available_flag_out(result_available_flag_out),
	.window_match_flag_out(window_match_flag_out));
`default_nettype wire

// [tb/adcrw_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module adcrw_regs_tb_top;
	import adcrw_pkg::*;
	logic clk_in, rst_n_in, psel, pen, pwr, halt, sev, st, ack, er, ac, rf, mf;
	logic [7:0] pa, pwd;
	logic [31:0] rd;
	logic [6:0] cnt;
	adcrw_sample_t smp_s;
	int n_mismatch = 0;
	int check_count = 0;
	// expected match per mode: bit j stands for the total 0x20 * (j + 1)
	logic [2:0] win_exp [6] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h5, 3'h0};
	adcrw_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in({24'h000000, pwd}), .prdata_out(rd), .pready_out(ack), .pslverr_out(er),
		.cpu_halted_in(halt), .start_event_in(sev), .sample_in(smp_s), .accum_count_in(cnt), .start_out(st),
		.adc_clk_out(ac), .result_available_flag_out(rf), .window_match_flag_out(mf));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task final_report;
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// a is the register index (byte address 4a); bit 8 of x is the expected error;
	// ready and read data are looked at half a cycle before the edge that samples them
	task xf(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] x);
		int i;
		logic [8:0] g;
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		pa <= {a[5:0], 2'h0};
		pwd <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		i = 0;
		do begin
			@(negedge clk_in);
			i++;
		end while (ack !== 1'b1 && i < 16);
		g = {er, (w || x[8]) ? 8'h00 : rd[7:0]};
		if (ack !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED %0t no ready", $time);
			final_report;
		end
		@(posedge clk_in);
		psel <= 1'b0;
		pen <= 1'b0;
		chk({7'h00, g}, {7'h00, x});
	endtask : xf
	task smp(input logic o, input logic b, input logic [9:0] c);
		@(posedge clk_in);
		smp_s <= {1'b1, o, b, c};
		@(posedge clk_in);
		smp_s.valid <= 1'b0;
	endtask : smp
	task ev(input logic x);
		@(posedge clk_in);
		sev <= 1'b1;
		@(posedge clk_in);
		sev <= 1'b0;
		@(negedge clk_in);
		chk({15'h0000, st}, {15'h0000, x});
		@(posedge clk_in);
	endtask : ev
	task duty(input logic [15:0] x);
		logic [15:0] h;
		h = 16'h0000;
		repeat (8) begin
			@(negedge clk_in);
			h += {15'h0000, ac};
		end
		chk(h, x);
	endtask : duty
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		xf(1'b0, ADCRW_OFS_DUTY, 8'h00, 9'h001);
		xf(1'b0, ADCRW_OFS_WIN_HIGH, 8'h00, 9'h000);
		xf(1'b0, ADCRW_OFS_STAGING, 8'h00, 9'h000);
		xf(1'b0, ADCRW_OFS_RESULT, 8'h00, 9'h000);
		duty(16'h0002);
		xf(1'b1, ADCRW_OFS_DUTY, 8'h00, 9'h000);
		duty(16'h0004);
	endtask : t_reset
	task t_regs;
		xf(1'b1, ADCRW_OFS_STAGING, 8'hA5, 9'h000);
		xf(1'b0, ADCRW_OFS_STAGING, 8'h00, 9'h0A5);
		xf(1'b1, 8'h12, 8'h34, 9'h000);
		xf(1'b1, 8'h13, 8'h12, 9'h000);
		xf(1'b1, 8'h14, 8'hCD, 9'h000);
		xf(1'b1, 8'h15, 8'hAB, 9'h000);
		xf(1'b0, 8'h12, 8'h00, 9'h034);
		xf(1'b0, ADCRW_OFS_STAGING, 8'h00, 9'h012);
		xf(1'b0, 8'h13, 8'h00, 9'h012);
		xf(1'b0, 8'h14, 8'h00, 9'h0CD);
		xf(1'b0, 8'h15, 8'h00, 9'h0AB);
		xf(1'b1, ADCRW_OFS_RESULT, 8'h55, 9'h100);
		xf(1'b0, 8'h1F, 8'h00, 9'h100);
	endtask : t_regs
	task t_conv;
		smp(1'b0, 1'b0, 10'h2A5);
		xf(1'b0, 8'h10, 8'h00, 9'h0A5);
		xf(1'b0, 8'h11, 8'h00, 9'h002);
		smp(1'b1, 1'b0, 10'h123);
		xf(1'b0, 8'h10, 8'h00, 9'h0FF);
		xf(1'b0, 8'h11, 8'h00, 9'h003);
		smp(1'b0, 1'b1, 10'h155);
		xf(1'b0, 8'h10, 8'h00, 9'h000);
		cnt <= ADCRW_ACC_MAX_SAMPLES;
		repeat (64) smp(1'b1, 1'b0, 10'h000);
		xf(1'b0, 8'h10, 8'h00, 9'h0C0);
		xf(1'b0, 8'h11, 8'h00, 9'h0FF);
	endtask : t_conv
	// thresholds 0x30 and 0x50 against totals of two samples; single samples would flag otherwise
	task t_win;
		xf(1'b1, 8'h12, 8'h30, 9'h000);
		xf(1'b1, 8'h13, 8'h00, 9'h000);
		xf(1'b1, 8'h14, 8'h50, 9'h000);
		xf(1'b1, 8'h15, 8'h00, 9'h000);
		cnt <= 7'h02;
		for (int k = 0; k < 6; k++) begin
			xf(1'b1, ADCRW_OFS_MODE, k[7:0], 9'h000);
			for (int j = 0; j < 3; j++) begin
				smp(1'b0, 1'b0, 10'(16 * (j + 1)));
				smp(1'b0, 1'b0, 10'(16 * (j + 1)));
				xf(1'b0, ADCRW_OFS_FLAGS, 8'h00, {7'h00, win_exp[k][j], 1'b1});
				xf(1'b0, 8'h10, 8'h00, {1'b0, 8'(32 * (j + 1))});
				xf(1'b0, ADCRW_OFS_FLAGS, 8'h00, 9'h000);
			end
		end
	endtask : t_win
	task t_debug;
		halt <= 1'b1;
		ev(1'b0);
		smp(1'b0, 1'b0, 10'h001);
		smp(1'b0, 1'b0, 10'h001);
		xf(1'b0, ADCRW_OFS_FLAGS, 8'h00, 9'h000);
		xf(1'b0, ADCRW_OFS_ACCUM, 8'h00, 9'h000);
		xf(1'b1, ADCRW_OFS_DEBUG, 8'h01, 9'h000);
		xf(1'b0, ADCRW_OFS_DEBUG, 8'h00, 9'h001);
		duty(16'h0004);
		ev(1'b1);
		smp(1'b0, 1'b0, 10'h001);
		xf(1'b0, ADCRW_OFS_ACCUM, 8'h00, 9'h001);
		smp(1'b0, 1'b0, 10'h001);
		xf(1'b0, ADCRW_OFS_FLAGS, 8'h00, 9'h001);
		xf(1'b1, ADCRW_OFS_FLAGS, 8'h01, 9'h000);
		xf(1'b0, ADCRW_OFS_FLAGS, 8'h00, 9'h000);
		halt <= 1'b0;
	endtask : t_debug
	// reset in mid-run brings back the documented reset values
	task t_rst2;
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		xf(1'b0, ADCRW_OFS_DEBUG, 8'h00, 9'h000);
		xf(1'b0, ADCRW_OFS_DUTY, 8'h00, 9'h001);
		xf(1'b0, ADCRW_OFS_RESULT, 8'h00, 9'h000);
	endtask : t_rst2
	initial begin
		rst_n_in = 1'b0;
		{psel, pen, pwr, halt, sev} = 5'h00;
		pa = 8'h00;
		pwd = 8'h00;
		cnt = 7'h01;
		smp_s = '0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset;
		t_regs;
		t_conv;
		t_win;
		t_debug;
		t_rst2;
		final_report;
	end
endmodule : adcrw_regs_tb_top
`default_nettype wire
